/* File: logic/fsf_cfg.svh */
`ifndef FSF_CFG_SVH
`define FSF_CFG_SVH

// ---------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------
`define FSF_ADDR_VOLT 8'h00
`define FSF_ADDR_SUPPLY 8'h01
`define FSF_ADDR_LATCH 8'h02
`define FSF_ADDR_LAT0 8'h2a
`define FSF_ADDR_LAT1 8'h2b
`define FSF_ADDR_LAT2 8'h2c

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define FSF_BIT_OCP_TIMEOUT 5
`define FSF_BIT_UNDERVOLT 6
`define FSF_BIT_OVERVOLT 7
`define FSF_BIT_SUPPLY_OV 0
`define FSF_BIT_EXT_REF 1
`define FSF_BIT_INT_REF 2
`define FSF_BIT_GND 3
`define FSF_BIT_SUPPLY_GOOD 4
`define FSF_BIT_REVERSE 5
`define FSF_BIT_ORING 6
`define FSF_BIT_SHARE 7
`define FSF_BIT_FAULT 0

// ---------------------------------------------------------------
// latched copies: index = (addr - 2Ah) * 8 + bit
// ---------------------------------------------------------------
`define FSF_LAT_BITS 24
`define FSF_BYTE_BITS 8
`define FSF_LAT_OFS0 0
`define FSF_LAT_OFS1 8
`define FSF_LAT_OFS2 16
`define FSF_LAT_MASK 24'h01_ffe0
`define FSF_RST_BYTE 8'h00
`define FSF_RST_LAT 24'h00_0000
`define FSF_RST_BIT 1'b0

`endif

/* File: logic/fsf_pkg.sv */
`include "fsf_cfg.svh"
package fsf_pkg;
    typedef logic [7:0] fsf_byte_t;
    typedef logic [`FSF_LAT_BITS-1:0] fsf_lat_t;
endpackage

/* File: logic/fsf_latch_bit.sv */
`timescale 1ns/1ps
`include "fsf_cfg.svh"

// sticky copy of one fault: cleared by a read of its register only
// when the fault has gone; a fault present in the clearing cycle wins
module fsf_latch_bit (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic q_o
);
    logic q;
    logic next_q;

    always_comb begin
        next_q = set_i | (q & ~clr_i);
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            q <= `FSF_RST_BIT;
        end else begin
            q <= next_q;
        end
    end

    assign q_o = q;
endmodule // fsf_latch_bit

/* File: logic/fsf_status_bank.sv */
// Operation
// - bit 6 of 00h reads high while an output undervoltage is detected.
// - bit 7 of 00h reads high while an output overvoltage is detected.
// - bit 0 of 01h reads high while the own supply is over its limit.
// - bit 1 of 01h reads low while the external reference is overloaded.
// - bit 2 of 01h reads low while the internal reference is unsound.
// - bit 3 of 01h reads low while the ground connection is open.
// - bit 4 of 01h is low on lockout, ref, ground, supply ov or pm fault.
// - bit 5 of 01h reads low on excessive reverse voltage at the switch.
// - bit 6 of 01h is the AND of pulse, enable, load and reverse good.
// - bit 7 of 01h reads low while current sharing is out of limits.
// - bit 0 of 02h latches high after an ov, uv or overcurrent event.
// - the overcurrent event is the timed-out flag at bit 5 of 00h.
// - latched copies clear on a read of their byte unless still faulty.
`timescale 1ns/1ps
`include "fsf_cfg.svh"

module fsf_status_bank (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // register access port
    input wire logic rd_en_i,
    input wire logic wr_en_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output logic rd_valid_o,
    // detector levels
    input wire logic undervolt_det_i,
    input wire logic overvolt_det_i,
    input wire logic ocp_timeout_i,
    input wire logic supply_ov_det_i,
    input wire logic ext_ref_overload_i,
    input wire logic int_ref_bad_i,
    input wire logic gnd_open_i,
    input wire logic supply_lockout_i,
    input wire logic pwr_mgmt_fail_i,
    input wire logic reverse_excess_i,
    input wire logic pulse_input_good_i,
    input wire logic power_enable_good_i,
    input wire logic load_voltage_good_i,
    input wire logic share_out_of_limit_i,
    // fault latch state
    output logic fault_latch_o
);
    // ---------------------------------------------------------------
    // live flags
    // ---------------------------------------------------------------
    logic supply_good;
    logic reverse_voltage_good;
    logic oring_switch_good;
    fsf_pkg::fsf_byte_t volt_byte;
    fsf_pkg::fsf_byte_t supply_byte;
    fsf_pkg::fsf_byte_t latch_byte;
    logic fault_latch;
    logic next_fault_latch;

    always_comb begin
        supply_good = ~(supply_lockout_i | pwr_mgmt_fail_i | ext_ref_overload_i
            | int_ref_bad_i | gnd_open_i | supply_ov_det_i);
        reverse_voltage_good = ~reverse_excess_i;
        oring_switch_good = pulse_input_good_i & power_enable_good_i
            & load_voltage_good_i & reverse_voltage_good;
    end

    // other bits of 00h and 02h belong to other blocks and read zero
    always_comb begin
        volt_byte = `FSF_RST_BYTE;
        volt_byte[`FSF_BIT_OCP_TIMEOUT] = ocp_timeout_i;
        volt_byte[`FSF_BIT_UNDERVOLT] = undervolt_det_i;
        volt_byte[`FSF_BIT_OVERVOLT] = overvolt_det_i;
        supply_byte = `FSF_RST_BYTE;
        supply_byte[`FSF_BIT_SUPPLY_OV] = supply_ov_det_i;
        supply_byte[`FSF_BIT_EXT_REF] = ~ext_ref_overload_i;
        supply_byte[`FSF_BIT_INT_REF] = ~int_ref_bad_i;
        supply_byte[`FSF_BIT_GND] = ~gnd_open_i;
        supply_byte[`FSF_BIT_SUPPLY_GOOD] = supply_good;
        supply_byte[`FSF_BIT_REVERSE] = reverse_voltage_good;
        supply_byte[`FSF_BIT_ORING] = oring_switch_good;
        supply_byte[`FSF_BIT_SHARE] = ~share_out_of_limit_i;
        latch_byte = `FSF_RST_BYTE;
        latch_byte[`FSF_BIT_FAULT] = fault_latch;
    end

    // ---------------------------------------------------------------
    // fault latch in 02h
    // ---------------------------------------------------------------
    // no clear but reset; its copy at 2Ch is set from it, so a read never clears that copy either

    always_comb begin
        next_fault_latch = fault_latch | overvolt_det_i | undervolt_det_i
            | ocp_timeout_i;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            fault_latch <= `FSF_RST_BIT;
        end else begin
            fault_latch <= next_fault_latch;
        end
    end

    assign fault_latch_o = fault_latch;

    // ---------------------------------------------------------------
    // latched copies at 2Ah..2Ch
    // ---------------------------------------------------------------
    fsf_pkg::fsf_lat_t lat_set;
    fsf_pkg::fsf_lat_t lat_q;

    always_comb begin
        lat_set = `FSF_RST_LAT;
        lat_set[`FSF_BIT_OCP_TIMEOUT] = ocp_timeout_i;
        lat_set[`FSF_BIT_UNDERVOLT] = undervolt_det_i;
        lat_set[`FSF_BIT_OVERVOLT] = overvolt_det_i;
        lat_set[`FSF_LAT_OFS1 + `FSF_BIT_SUPPLY_OV] = supply_ov_det_i;
        lat_set[`FSF_LAT_OFS1 + `FSF_BIT_EXT_REF] = ext_ref_overload_i;
        lat_set[`FSF_LAT_OFS1 + `FSF_BIT_INT_REF] = int_ref_bad_i;
        lat_set[`FSF_LAT_OFS1 + `FSF_BIT_GND] = gnd_open_i;
        lat_set[`FSF_LAT_OFS1 + `FSF_BIT_SUPPLY_GOOD] = ~supply_good;
        lat_set[`FSF_LAT_OFS1 + `FSF_BIT_REVERSE] = ~reverse_voltage_good;
        lat_set[`FSF_LAT_OFS1 + `FSF_BIT_ORING] = ~oring_switch_good;
        lat_set[`FSF_LAT_OFS1 + `FSF_BIT_SHARE] = share_out_of_limit_i;
        lat_set[`FSF_LAT_OFS2 + `FSF_BIT_FAULT] = fault_latch;
    end

    localparam fsf_pkg::fsf_lat_t LAT_MASK = `FSF_LAT_MASK;

    genvar gi;
    generate
        for (gi = 0; gi < `FSF_LAT_BITS; gi = gi + 1) begin : g_lat
            if (LAT_MASK[gi]) begin : g_used
                localparam logic [7:0] REG_ADDR =
                    `FSF_ADDR_LAT0 + 8'(gi / `FSF_BYTE_BITS);
                logic clr;
                assign clr = rd_en_i && (addr_i == REG_ADDR);
                fsf_latch_bit u_bit (
                    .sys_clk_i(sys_clk_i),
                    .rst_n_i(rst_n_i),
                    .set_i(lat_set[gi]),
                    .clr_i(clr),
                    .q_o(lat_q[gi])
                );
            end else begin : g_unused
                assign lat_q[gi] = `FSF_RST_BIT;
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // read port
    // ---------------------------------------------------------------
    // data is the value before any read-clear of the same edge;
    // wdata_i and wr_en_i reach no storage at all
    fsf_pkg::fsf_byte_t rdata;
    fsf_pkg::fsf_byte_t next_rdata;
    logic rd_valid;
    logic next_rd_valid;

    always_comb begin
        next_rdata = rdata;
        next_rd_valid = rd_en_i;
        if (rd_en_i) begin
            case (addr_i)
                `FSF_ADDR_VOLT: next_rdata = volt_byte;
                `FSF_ADDR_SUPPLY: next_rdata = supply_byte;
                `FSF_ADDR_LATCH: next_rdata = latch_byte;
                `FSF_ADDR_LAT0:
                    next_rdata = lat_q[`FSF_LAT_OFS0 +: `FSF_BYTE_BITS];
                `FSF_ADDR_LAT1:
                    next_rdata = lat_q[`FSF_LAT_OFS1 +: `FSF_BYTE_BITS];
                `FSF_ADDR_LAT2:
                    next_rdata = lat_q[`FSF_LAT_OFS2 +: `FSF_BYTE_BITS];
                default: next_rdata = `FSF_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rdata <= `FSF_RST_BYTE;
            rd_valid <= `FSF_RST_BIT;
        end else begin
            rdata <= next_rdata;
            rd_valid <= next_rd_valid;
        end
    end

    assign rdata_o = rdata;
    assign rd_valid_o = rd_valid;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_rd_volt;
        rd_en_i && addr_i == `FSF_ADDR_VOLT;
    endsequence
    sequence s_rd_supply;
        rd_en_i && addr_i == `FSF_ADDR_SUPPLY;
    endsequence
    sequence s_rd_lat0;
        rd_en_i && addr_i == `FSF_ADDR_LAT0;
    endsequence
    sequence s_rd_latch;
        rd_en_i && addr_i == `FSF_ADDR_LATCH;
    endsequence
    sequence s_rd_lat1;
        rd_en_i && addr_i == `FSF_ADDR_LAT1;
    endsequence
    sequence s_rd_lat2;
        rd_en_i && addr_i == `FSF_ADDR_LAT2;
    endsequence

    a_uv_flag_read: assert property (s_rd_volt |=> rd_valid_o
        && rdata_o[`FSF_BIT_UNDERVOLT] == $past(undervolt_det_i))
        else $error("undervoltage flag read wrong");
    a_ov_flag_read: assert property (s_rd_volt |=>
        rdata_o[`FSF_BIT_OVERVOLT] == $past(overvolt_det_i))
        else $error("overvoltage flag read wrong");
    a_supply_ov_read: assert property (s_rd_supply |=>
        rdata_o[`FSF_BIT_SUPPLY_OV] == $past(supply_ov_det_i))
        else $error("supply overvoltage flag wrong");
    a_ext_ref_read: assert property (s_rd_supply |=>
        rdata_o[`FSF_BIT_EXT_REF] == !$past(ext_ref_overload_i))
        else $error("external reference flag wrong");
    a_int_ref_read: assert property (s_rd_supply |=>
        rdata_o[`FSF_BIT_INT_REF] == !$past(int_ref_bad_i))
        else $error("internal reference flag wrong");
    a_gnd_flag_read: assert property (s_rd_supply |=>
        rdata_o[`FSF_BIT_GND] == !$past(gnd_open_i))
        else $error("ground flag wrong");
    a_supply_good_low: assert property ((s_rd_supply
        ##0 (supply_lockout_i || pwr_mgmt_fail_i || gnd_open_i))
        |=> !rdata_o[`FSF_BIT_SUPPLY_GOOD])
        else $error("supply good not low on fault");
    a_reverse_read: assert property (s_rd_supply |=>
        rdata_o[`FSF_BIT_REVERSE] == !$past(reverse_excess_i))
        else $error("reverse voltage flag wrong");
    a_oring_and: assert property (s_rd_supply |=>
        rdata_o[`FSF_BIT_ORING] == ($past(pulse_input_good_i)
        && $past(power_enable_good_i) && $past(load_voltage_good_i)
        && !$past(reverse_excess_i)))
        else $error("oring switch flag not the AND");
    a_share_read: assert property (s_rd_supply |=>
        rdata_o[`FSF_BIT_SHARE] == !$past(share_out_of_limit_i))
        else $error("share flag wrong");
    a_fault_latch_set: assert property ((overvolt_det_i ||
        undervolt_det_i || ocp_timeout_i) |=> fault_latch_o [*3])
        else $error("fault latch not set and held");
    a_ocp_to_latch: assert property (ocp_timeout_i
        |=> fault_latch_o) else $error("overcurrent missed latch");
    a_lat_hold_fault: assert property ((s_rd_lat0 ##0
        undervolt_det_i) |=> lat_q[`FSF_BIT_UNDERVOLT])
        else $error("latched copy cleared while fault present");
    a_lat_read_clear: assert property ((s_rd_lat0 ##0
        !undervolt_det_i) |=> !lat_q[`FSF_BIT_UNDERVOLT])
        else $error("latched copy not cleared by read");
    a_write_ignored: assert property ((wr_en_i && !rd_en_i)
        |=> lat_q == ($past(lat_q) | $past(lat_set)))
        else $error("write changed latched state");
    a_read_no_clear: assert property (s_rd_volt |=>
        fault_latch_o == $past(next_fault_latch)
        && lat_q == ($past(lat_q) | $past(lat_set)))
        else $error("read disturbed fault latch");
    a_ocp_flag_read: assert property (s_rd_volt |=>
        rdata_o[`FSF_BIT_OCP_TIMEOUT] == $past(ocp_timeout_i))
        else $error("overcurrent timeout flag wrong");
    a_supply_good_all: assert property (s_rd_supply |=>
        rdata_o[`FSF_BIT_SUPPLY_GOOD] == !($past(supply_lockout_i)
        || $past(pwr_mgmt_fail_i) || $past(ext_ref_overload_i)
        || $past(int_ref_bad_i) || $past(gnd_open_i)
        || $past(supply_ov_det_i)))
        else $error("supply good not the NOR of its faults");
    a_latch_byte_read: assert property (s_rd_latch |=>
        rdata_o == {7'h00, $past(fault_latch_o)})
        else $error("fault latch register read wrong");
    a_fault_latch_hold: assert property (fault_latch_o |=>
        fault_latch_o) else $error("fault latch dropped without reset");
    a_lat_sets: assert property (overvolt_det_i |=>
        lat_q[`FSF_BIT_OVERVOLT]) else $error("latched copy not set");
    a_lat_sov_sets: assert property (supply_ov_det_i |=>
        lat_q[`FSF_LAT_OFS1 + `FSF_BIT_SUPPLY_OV])
        else $error("latched supply overvoltage not set");
    a_lat_ext_hold: assert property ((s_rd_lat1 ##0
        ext_ref_overload_i) |=> lat_q[`FSF_LAT_OFS1 + `FSF_BIT_EXT_REF])
        else $error("latched reference fault cleared while present");
    a_fault_copy_hold: assert property ((s_rd_lat2 ##0
        fault_latch_o) |=> lat_q[`FSF_LAT_OFS2 + `FSF_BIT_FAULT])
        else $error("fault latch copy cleared while latch set");
    a_rd_valid_pulse: assert property (rd_en_i |=> rd_valid_o)
        else $error("read not answered next cycle");
    a_port_quiet: assert property (!rd_en_i |=> !rd_valid_o
        && $stable(rdata_o)) else $error("port moved without a read");
    a_unmapped_zero: assert property ((rd_en_i && !(addr_i inside
        {`FSF_ADDR_VOLT, `FSF_ADDR_SUPPLY, `FSF_ADDR_LATCH, `FSF_ADDR_LAT0,
        `FSF_ADDR_LAT1, `FSF_ADDR_LAT2})) |=> rdata_o == `FSF_RST_BYTE)
        else $error("unmapped address read not zero");
endmodule // fsf_status_bank

/* File: test/fsf_host_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// host side of the status port
// ---------------------------------------------------------------
module fsf_host_model (
    input wire logic sys_clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic rd_valid_i,
    output logic rd_en_o,
    output logic wr_en_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o
);
    initial begin
        rd_en_o = 1'b0;
        wr_en_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    // one-cycle strobe; the answer is awaited under a bound
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output bit ok);
        @(negedge sys_clk_i);
        addr_o = a;
        rd_en_o = 1'b1;
        @(negedge sys_clk_i);
        rd_en_o = 1'b0;
        addr_o = ~a;
        ok = 1'b0;
        d = 8'h00;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (rd_valid_i === 1'b1) begin
                ok = 1'b1;
                d = rdata_i;
            end else begin
                @(negedge sys_clk_i);
            end
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge sys_clk_i);
        addr_o = a;
        wdata_o = v;
        wr_en_o = 1'b1;
        @(negedge sys_clk_i);
        wr_en_o = 1'b0;
        wdata_o = ~v;
    endtask
    // a latched register is read again until it shows no fault
    task automatic rd_until_clear(input logic [7:0] a, input int tries,
                                  output int n, output bit ok);
        logic [7:0] d;
        bit v;
        ok = 1'b0;
        n = 0;
        while (!ok && n < tries) begin
            rd(a, d, v);
            n++;
            ok = v && (d === 8'h00);
        end
    endtask
endmodule // fsf_host_model

/* File: test/fault_status_flags_tb.sv */
`timescale 1ns/1ps
module fault_status_flags_tb;
    // detector order: sov ext int gnd lock pmf rev pulse pen load
    // share ocp uv ov; good-level inputs idle high
    localparam logic [13:0] BASE = 14'h0380;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [13:0] det = BASE;
    logic [13:0] flt;
    logic rd_en, wr_en, rd_valid, fault_latch, lat;
    logic [7:0] addr, wdata, rdata;
    int fail_count = 0;
    int checks = 0;
    int n;
    bit ok;
    always #12.5 sys_clk_i = ~sys_clk_i;

    fsf_status_bank i_fsf_status_bank (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .rd_en_i(rd_en), .wr_en_i(wr_en), .addr_i(addr),
        .wdata_i(wdata), .rdata_o(rdata), .rd_valid_o(rd_valid),
        .supply_ov_det_i(det[0]), .ext_ref_overload_i(det[1]),
        .int_ref_bad_i(det[2]), .gnd_open_i(det[3]),
        .supply_lockout_i(det[4]), .pwr_mgmt_fail_i(det[5]),
        .reverse_excess_i(det[6]), .pulse_input_good_i(det[7]),
        .power_enable_good_i(det[8]), .load_voltage_good_i(det[9]),
        .share_out_of_limit_i(det[10]), .ocp_timeout_i(det[11]),
        .undervolt_det_i(det[12]), .overvolt_det_i(det[13]),
        .fault_latch_o(fault_latch)
    );
    fsf_host_model i_fsf_host_model (
        .sys_clk_i(sys_clk_i), .rdata_i(rdata), .rd_valid_i(rd_valid),
        .rd_en_o(rd_en), .wr_en_o(wr_en), .addr_o(addr),
        .wdata_o(wdata)
    );

    // ---------------------------------------------------------------
    // expectations and checks
    // ---------------------------------------------------------------
    function automatic logic [7:0] live(input logic [7:0] a,
                                       input logic [13:0] d);
        case (a)
            8'h00: return {d[13], d[12], d[11], 5'h00};
            8'h01: return {~d[10], d[7] & d[8] & d[9] & ~d[6], ~d[6],
                           ~|d[5:0], ~d[3], ~d[2], ~d[1], d[0]};
            default: return 8'h00;
        endcase
    endfunction
    task automatic close_out();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // strobe must be gone one cycle after it showed
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        bit v;
        i_fsf_host_model.rd(a, d, v);
        if (!v) begin
            fail_count++;
            close_out();
        end
        chk("rdata", e, d);
        @(negedge sys_clk_i);
        chk("rd_valid", 8'h00, {7'h00, rd_valid});
    endtask

    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial begin
        lat = 1'b0;
        repeat (16) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            i_fsf_host_model.wr(i == 3 ? 8'h2a : 8'(i), 8'hff);
        end
        chk("latch", 8'h00, {7'h00, fault_latch});
        rchk(8'h02, 8'h00);
        rchk(8'h03, 8'h00);
        for (int i = 0; i < 14; i++) begin
            @(negedge sys_clk_i);
            det = BASE ^ (14'h0001 << i);
            lat = lat | det[11] | det[12] | det[13];
            rchk(8'h00, live(8'h00, det));
            rchk(8'h01, live(8'h01, det));
            rchk(8'h01, live(8'h01, det));
            rchk(8'h02, {7'h00, lat});
        end
        @(negedge sys_clk_i);
        rst_n_i = 1'b0;
        det = BASE;
        repeat (2) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        rchk(8'h2b, 8'h00);
        det[1] = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        det = BASE;
        rchk(8'h2b, 8'h12);
        rchk(8'h2b, 8'h00);
        det[3] = 1'b1;
        rchk(8'h2b, 8'h18);
        rchk(8'h2b, 8'h18);
        det = BASE;
        i_fsf_host_model.rd_until_clear(8'h2b, 4, n, ok);
        chk("reads", 8'h02, 8'(n));
        chk("cleared", 8'h01, {7'h00, ok});
        // every 01h item sets its own latched fault bit in 2Bh
        for (int i = 0; i < 11; i++) begin
            flt = BASE ^ (14'h0001 << i);
            det = flt;
            rchk(8'h2b, live(8'h01, flt) ^ 8'hfe);
            rchk(8'h2b, live(8'h01, flt) ^ 8'hfe);
            det = BASE;
            rchk(8'h2b, live(8'h01, flt) ^ 8'hfe);
            rchk(8'h2b, 8'h00);
        end
        det[11] = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        det = BASE;
        rchk(8'h2a, 8'h20);
        rchk(8'h2a, 8'h00);
        det[13:12] = 2'b11;
        rchk(8'h2a, 8'hc0);
        rchk(8'h2a, 8'hc0);
        det = BASE;
        rchk(8'h2a, 8'hc0);
        rchk(8'h2a, 8'h00);
        rchk(8'h2c, 8'h01);
        rchk(8'h2c, 8'h01);
        chk("latch", 8'h01, {7'h00, fault_latch});
        close_out();
    end
endmodule // fault_status_flags_tb
